//--- rtl/otsr_pkg.sv
// Constants, types and summary for the octal transceiver scan registers
// Summary of operation
// - Eight-bit instruction picks mode and register.
// - Opcode bit 7 is ignored in decode.
// - No parity check; unknown opcodes act as bypass.
// - Capture-IR loads fixed pattern 10000001.
// - Instruction takes effect only at Update-IR.
// - Reset and Test-Logic-Reset set instruction 11111111.
// - Eighteen-bit boundary chain with control cells.
// - Chain shifts TDI into 17, out of 0.
// - Boundary cells kept in reset; idle ops per instruction.
// - Cell 17 direction, 16 enable, 15-8 in, 7-0 out.
// - Direction 0: B inputs; 1: A inputs.
// - Normal mode direction follows direction pin.
// - Two-bit control register, resets to 10.
// - Control register holds value during Capture-DR.
// - One-bit bypass register shortens scan path.
// - Bypass opcodes capture 0, normal mode.
// - Tristate, clamp and run-test bypass in test modes.
// - Read, self test, toggle, control scan opcodes.
// - Boundary scan opcodes: test mode, cells drive.
// - Sample opcode: normal mode, cells capture.
// - Control codes: toggle, pattern, signature, combined.
// - Self test captures inverse of cells.
// - Boundary reads hold chain during Capture-DR.
// - Tristate instruction disables all outputs.
package otsr_pkg;
  localparam int IR_W = 8;
  localparam int BSR_W = 18;
  localparam int BCR_W = 2;
  localparam int DAT_W = 8;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] IR_RESET = 8'hFF;
  localparam logic [1:0] BCR_RESET = 2'h2;
  localparam int BSR_DIR = 17;
  localparam int BSR_OE_B = 16;
  localparam int BSR_IN_LO = 8;
  localparam int BSR_OUT_LO = 0;
  // Seven decoded opcode bits
  localparam logic [6:0] OP_BSCAN_A = 7'h00;
  localparam logic [6:0] OP_BYP_A = 7'h01;
  localparam logic [6:0] OP_SAMPLE = 7'h02;
  localparam logic [6:0] OP_BSCAN_B = 7'h03;
  localparam logic [6:0] OP_BYP_B = 7'h04;
  localparam logic [6:0] OP_BYP_C = 7'h05;
  localparam logic [6:0] OP_TRISTATE = 7'h06;
  localparam logic [6:0] OP_CLAMP = 7'h07;
  localparam logic [6:0] OP_BYP_D = 7'h08;
  localparam logic [6:0] OP_RUN_TEST = 7'h09;
  localparam logic [6:0] OP_READ_N = 7'h0A;
  localparam logic [6:0] OP_READ_T = 7'h0B;
  localparam logic [6:0] OP_SELF_TEST = 7'h0C;
  localparam logic [6:0] OP_TOGGLE = 7'h0D;
  localparam logic [6:0] OP_CTRL_N = 7'h0E;
  localparam logic [6:0] OP_CTRL_T = 7'h0F;
  typedef enum logic [1:0] {SEL_BYPASS = 2'b00, SEL_BOUNDARY = 2'b01,
    SEL_CONTROL = 2'b10} otsr_sel_t;
  typedef enum logic [1:0] {MODE_NORMAL = 2'b00, MODE_TEST = 2'b01,
    MODE_HIGHZ = 2'b10} otsr_mode_t;
  typedef enum logic [1:0] {CAP_PINS = 2'b00, CAP_HOLD = 2'b01,
    CAP_INVERT = 2'b10, CAP_ZERO = 2'b11} otsr_cap_t;
  typedef enum logic [1:0] {RUN_NONE = 2'b00, RUN_CONTROL = 2'b01,
    RUN_TOGGLE = 2'b10} otsr_run_t;
  typedef enum logic [1:0] {BCR_SAMPLE_TOGGLE = 2'b00, BCR_PATTERN = 2'b01,
    BCR_SIGNATURE = 2'b10, BCR_COMBINED = 2'b11} otsr_bcr_t;
  typedef struct packed {otsr_sel_t sel; otsr_mode_t mode;
    otsr_cap_t cap; otsr_run_t run;} otsr_dec_t;
  typedef struct packed {logic dir; logic oe_b;
    logic [DAT_W-1:0] a; logic [DAT_W-1:0] b;} otsr_pins_t;
  typedef struct packed {otsr_mode_t mode; logic [BSR_W-1:0] cells;} otsr_xfer_t;
  // Test clock domain state
  typedef struct packed {
    otsr_pins_t pin_s1; otsr_pins_t pin_s2;
    logic [IR_W-1:0] ir_shift; logic [IR_W-1:0] ir;
    logic [BSR_W-1:0] bsr_shift; logic [BSR_W-1:0] bsr_shadow;
    logic [BCR_W-1:0] bcr_shift; logic [BCR_W-1:0] boundary_control;
    logic byp; logic xfer_tgl; otsr_xfer_t xfer; logic out_bit;
  } otsr_tck_t;
  // System clock domain state
  typedef struct packed {
    logic tgl_s1; logic tgl_s2; logic tgl_s3;
    otsr_pins_t pin_s1; otsr_pins_t pin_s2; otsr_xfer_t xfer;
    logic [DAT_W-1:0] a_out; logic [DAT_W-1:0] b_out; logic a_oe; logic b_oe;
  } otsr_sys_t;
endpackage

//--- rtl/otsr_scan_regs.sv
// Scan registers, opcode decode and pin path of the octal transceiver
`timescale 1ns/1ps
module otsr_scan_regs
  import otsr_pkg::*;
#(
  parameter logic [15:0] TAPS16 = 16'hD008,
  parameter logic [7:0] TAPS8 = 8'hB8
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic TCK,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  input wire logic TAP_RESET,
  input wire logic TAP_IDLE,
  input wire logic TAP_CAPTURE_IR,
  input wire logic TAP_SHIFT_IR,
  input wire logic TAP_UPDATE_IR,
  input wire logic TAP_CAPTURE_DR,
  input wire logic TAP_SHIFT_DR,
  input wire logic TAP_UPDATE_DR,
  input wire logic DIR_PIN,
  input wire logic OE_B_PIN,
  input wire logic [DAT_W-1:0] A_IN,
  output logic [DAT_W-1:0] A_OUT,
  output logic A_OE,
  input wire logic [DAT_W-1:0] B_IN,
  output logic [DAT_W-1:0] B_OUT,
  output logic B_OE
);

  // ************************************************************
  // Decode helpers
  // ************************************************************

  // Opcode to register, mode, capture source and idle operation
  function automatic otsr_dec_t otsr_decode(input logic [6:0] op);
    otsr_dec_t d;
    // Any code not listed falls back to plain bypass
    d = '{SEL_BYPASS, MODE_NORMAL, CAP_ZERO, RUN_NONE};
    case (op)
      OP_BSCAN_A, OP_BSCAN_B: begin
        d = '{SEL_BOUNDARY, MODE_TEST, CAP_PINS, RUN_NONE};
      end
      OP_SAMPLE: begin
        d = '{SEL_BOUNDARY, MODE_NORMAL, CAP_PINS, RUN_NONE};
      end
      OP_BYP_A, OP_BYP_B, OP_BYP_C, OP_BYP_D: begin
        d = '{SEL_BYPASS, MODE_NORMAL, CAP_ZERO, RUN_NONE};
      end
      OP_TRISTATE: begin
        d = '{SEL_BYPASS, MODE_HIGHZ, CAP_ZERO, RUN_NONE};
      end
      OP_CLAMP: begin
        d = '{SEL_BYPASS, MODE_TEST, CAP_ZERO, RUN_NONE};
      end
      OP_RUN_TEST: begin
        d = '{SEL_BYPASS, MODE_TEST, CAP_ZERO, RUN_CONTROL};
      end
      OP_READ_N: begin
        d = '{SEL_BOUNDARY, MODE_NORMAL, CAP_HOLD, RUN_NONE};
      end
      OP_READ_T: begin
        d = '{SEL_BOUNDARY, MODE_TEST, CAP_HOLD, RUN_NONE};
      end
      OP_SELF_TEST: begin
        d = '{SEL_BOUNDARY, MODE_NORMAL, CAP_INVERT, RUN_NONE};
      end
      OP_TOGGLE: begin
        d = '{SEL_BYPASS, MODE_TEST, CAP_ZERO, RUN_TOGGLE};
      end
      OP_CTRL_N: begin
        d = '{SEL_CONTROL, MODE_NORMAL, CAP_HOLD, RUN_NONE};
      end
      OP_CTRL_T: begin
        d = '{SEL_CONTROL, MODE_TEST, CAP_HOLD, RUN_NONE};
      end
      default: begin
        d = '{SEL_BYPASS, MODE_NORMAL, CAP_ZERO, RUN_NONE};
      end
    endcase
    return d;
  endfunction

  // One step of a 16-bit feedback shift register
  function automatic logic [15:0] otsr_lfsr16(input logic [15:0] x);
    return {x[14:0], ^(x & TAPS16)};
  endfunction

  // One step of an 8-bit feedback shift register
  function automatic logic [7:0] otsr_lfsr8(input logic [7:0] x);
    return {x[6:0], ^(x & TAPS8)};
  endfunction

  // ************************************************************
  // Test clock domain signals
  // ************************************************************

  otsr_tck_t t_r; // Registered scan state
  otsr_tck_t t_nxt; // Next scan state
  otsr_pins_t pins_in; // Raw pin levels, not yet synchronised
  otsr_dec_t dec; // Decoded current instruction
  logic test_tck; // Boundary cells own the core and pins
  logic eff_dir; // Direction seen by the cells
  logic [DAT_W-1:0] in_data; // Synchronised input port data
  logic [DAT_W-1:0] core_in; // What the buffer core receives
  logic [BSR_W-1:0] cap_word; // Capture value for sampling opcodes
  logic [15:0] run_v; // Data cells after one idle step
  logic run_keep_out; // Output shadows stay put this step
  logic tdo_bit; // Bit that the selected register presents
  logic tdo_r; // Falling-edge TDO data
  logic tdo_oe_r; // Falling-edge TDO enable

  assign pins_in = '{DIR_PIN, OE_B_PIN, A_IN, B_IN};

  // Decode uses only the shadow copy, never the shift stage
  assign dec = otsr_decode(t_r.ir[IR_W-2:0]);

  // Test mode hands the core and direction to the shadows
  assign test_tck = (dec.mode == MODE_TEST);
  assign eff_dir = test_tck ? t_r.bsr_shadow[BSR_DIR] : t_r.pin_s2.dir;
  // Direction 0 makes B the input port
  assign in_data = eff_dir ? t_r.pin_s2.a : t_r.pin_s2.b;
  assign core_in = test_tck ? t_r.bsr_shadow[BSR_IN_LO +: DAT_W] : in_data;
  // Core is a plain buffer, so its outputs equal its inputs
  assign cap_word = {t_r.pin_s2.dir, t_r.pin_s2.oe_b, in_data, core_in};

  // ************************************************************
  // Idle test operations
  // ************************************************************

  // Step the data cells 15..0; control cells never take part
  always_comb begin
    run_v = t_r.bsr_shift[15:0];
    run_keep_out = 1'b0;
    if (dec.run == RUN_TOGGLE) begin
      // Inputs hold, outputs invert
      run_v = {t_r.bsr_shift[15:8], ~t_r.bsr_shift[7:0]};
    end else begin
      case (otsr_bcr_t'(t_r.boundary_control))
        BCR_SAMPLE_TOGGLE: begin
          run_v = {in_data, ~t_r.bsr_shift[7:0]};
        end
        BCR_PATTERN: begin
          run_v = otsr_lfsr16(t_r.bsr_shift[15:0]);
        end
        BCR_SIGNATURE: begin
          // Outputs keep driving their old shadow values
          run_v = otsr_lfsr16(t_r.bsr_shift[15:0]) ^ {in_data, 8'h00};
          run_keep_out = 1'b1;
        end
        default: begin
          run_v = {otsr_lfsr8(t_r.bsr_shift[15:8]) ^ in_data,
                   otsr_lfsr8(t_r.bsr_shift[7:0])};
        end
      endcase
    end
  end

  // ************************************************************
  // Scan register next state
  // ************************************************************

  // Instruction, data registers and the crossing word
  always_comb begin
    t_nxt = t_r;
    t_nxt.pin_s1 = pins_in;
    t_nxt.pin_s2 = t_r.pin_s1;
    if (TAP_RESET) begin
      // Reset state: instruction and control reset, chain untouched
      t_nxt.ir = IR_RESET;
      t_nxt.boundary_control = BCR_RESET;
      // Shift stage too, so a first scan reads back the reset code
      t_nxt.bcr_shift = BCR_RESET;
    end else begin
      // Instruction path
      if (TAP_CAPTURE_IR) begin
        t_nxt.ir_shift = IR_CAPTURE;
      end else if (TAP_SHIFT_IR) begin
        t_nxt.ir_shift = {TDI, t_r.ir_shift[IR_W-1:1]};
        // Keep the bit that leaves, so no captured bit is lost
        t_nxt.out_bit = t_r.ir_shift[0];
      end
      if (TAP_UPDATE_IR) begin
        t_nxt.ir = t_r.ir_shift;
      end
      // Data register capture or shift
      if (TAP_CAPTURE_DR) begin
        case (dec.sel)
          SEL_BOUNDARY: begin
            case (dec.cap)
              CAP_PINS: begin
                t_nxt.bsr_shift = cap_word;
              end
              CAP_INVERT: begin
                t_nxt.bsr_shift = ~t_r.bsr_shadow;
              end
              default: begin
                t_nxt.bsr_shift = t_r.bsr_shift;
              end
            endcase
          end
          SEL_CONTROL: begin
            t_nxt.bcr_shift = t_r.bcr_shift;
          end
          default: begin
            t_nxt.byp = 1'b0;
          end
        endcase
      end else if (TAP_SHIFT_DR) begin
        case (dec.sel)
          SEL_BOUNDARY: begin
            t_nxt.bsr_shift = {TDI, t_r.bsr_shift[BSR_W-1:1]};
            t_nxt.out_bit = t_r.bsr_shift[0];
          end
          SEL_CONTROL: begin
            t_nxt.bcr_shift = {TDI, t_r.bcr_shift[BCR_W-1:1]};
            t_nxt.out_bit = t_r.bcr_shift[0];
          end
          default: begin
            t_nxt.byp = TDI;
            t_nxt.out_bit = t_r.byp;
          end
        endcase
      end
      // Update: shadows take the shift stage
      if (TAP_UPDATE_DR) begin
        case (dec.sel)
          SEL_BOUNDARY: begin
            t_nxt.bsr_shadow = t_r.bsr_shift;
          end
          SEL_CONTROL: begin
            t_nxt.boundary_control = t_r.bcr_shift;
          end
          default: begin
          end
        endcase
      end
      // Idle operations touch only what the instruction asks for
      if (TAP_IDLE && (dec.run != RUN_NONE)) begin
        t_nxt.bsr_shift[15:0] = run_v;
        t_nxt.bsr_shadow[15:8] = run_v[15:8];
        if (!run_keep_out) begin
          t_nxt.bsr_shadow[7:0] = run_v[7:0];
        end
      end
    end
    // Publish mode and shadows whenever either moves
    if ((t_nxt.ir != t_r.ir) || (t_nxt.bsr_shadow != t_r.bsr_shadow)) begin
      t_nxt.xfer_tgl = ~t_r.xfer_tgl;
      t_nxt.xfer.mode = otsr_decode(t_nxt.ir[IR_W-2:0]).mode;
      t_nxt.xfer.cells = t_nxt.bsr_shadow;
    end
  end

  // Scan state register; power-up matches Test-Logic-Reset
  always_ff @(posedge TCK or negedge RST_B) begin
    if (!RST_B) begin
      t_r <= '0;
      t_r.ir <= IR_RESET;
      t_r.boundary_control <= BCR_RESET;
      t_r.bcr_shift <= BCR_RESET;
    end else begin
      t_r <= t_nxt;
    end
  end

  // ************************************************************
  // Test data out
  // ************************************************************

  // Bit shifted out of the selected register at the last rising edge
  always_comb begin
    tdo_bit = t_r.out_bit;
  end

  // Falling edge gives the tester half a period of setup
  always_ff @(negedge TCK or negedge RST_B) begin
    if (!RST_B) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r <= tdo_bit;
      tdo_oe_r <= TAP_SHIFT_IR | TAP_SHIFT_DR;
    end
  end

  assign TDO = tdo_r;
  assign TDO_OE = tdo_oe_r;

  // ************************************************************
  // System clock domain: transceiver path
  // ************************************************************

  otsr_sys_t s_r; // Registered pin path state
  otsr_sys_t s_nxt; // Next pin path state
  logic sys_test; // Shadows drive the pins
  logic sys_dir; // Effective direction at the pins
  logic sys_oe_b; // Effective active-low enable
  logic [DAT_W-1:0] sys_data; // Data toward the output port
  logic sys_drive; // Output port may drive

  assign sys_test = (s_r.xfer.mode == MODE_TEST);
  assign sys_dir = sys_test ? s_r.xfer.cells[BSR_DIR] : s_r.pin_s2.dir;
  assign sys_oe_b = sys_test ? s_r.xfer.cells[BSR_OE_B] : s_r.pin_s2.oe_b;
  assign sys_data = sys_test ? s_r.xfer.cells[BSR_OUT_LO +: DAT_W] :
                    (sys_dir ? s_r.pin_s2.a : s_r.pin_s2.b);
  // Tristate mode kills every output, inputs still flow
  assign sys_drive = !sys_oe_b && (s_r.xfer.mode != MODE_HIGHZ);

  // Word crossing by toggle; the word is held for a whole test
  // clock period, far longer than the three-flop sync needs
  always_comb begin
    s_nxt = s_r;
    s_nxt.pin_s1 = pins_in;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.tgl_s1 = t_r.xfer_tgl;
    s_nxt.tgl_s2 = s_r.tgl_s1;
    s_nxt.tgl_s3 = s_r.tgl_s2;
    if (s_r.tgl_s2 != s_r.tgl_s3) begin
      s_nxt.xfer = t_r.xfer;
    end
    // Direction 0: A is the output port
    s_nxt.a_oe = sys_drive && !sys_dir;
    s_nxt.b_oe = sys_drive && sys_dir;
    s_nxt.a_out = sys_data;
    s_nxt.b_out = sys_data;
  end

  // Pin path register
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign A_OUT = s_r.a_out;
  assign B_OUT = s_r.b_out;
  assign A_OE = s_r.a_oe;
  assign B_OE = s_r.b_oe;

  // ************************************************************
  // Assertions
  // ************************************************************

  sequence s_ir_update;
    TAP_UPDATE_IR && !TAP_RESET;
  endsequence

  sequence s_ir_takes;
    t_r.ir == $past(t_r.ir_shift);
  endsequence

  a_ir_reset_value: assert property (
    @(posedge TCK) disable iff (!RST_B) TAP_RESET |=> (t_r.ir == 8'hFF))
    else $error("instruction not reset to all ones");

  a_ir_capture_pat: assert property (
    @(posedge TCK) disable iff (!RST_B)
    (TAP_CAPTURE_IR && !TAP_RESET) |=> (t_r.ir_shift == 8'h81))
    else $error("capture-ir pattern wrong");

  a_ir_update_load: assert property (
    @(posedge TCK) disable iff (!RST_B) s_ir_update |=> s_ir_takes)
    else $error("instruction not loaded at update");

  a_ir_held_between: assert property (
    @(posedge TCK) disable iff (!RST_B)
    (!TAP_UPDATE_IR && !TAP_RESET) |=> $stable(t_r.ir))
    else $error("instruction changed outside update");

  a_bit7_dont_care: assert property (
    @(posedge TCK) disable iff (!RST_B)
    s_ir_update |=> (dec == otsr_decode($past(t_r.ir_shift[6:0]))))
    else $error("bit 7 altered the decode");

  a_bypass_zero: assert property (
    @(posedge TCK) disable iff (!RST_B)
    (TAP_CAPTURE_DR && !TAP_RESET && dec.sel == SEL_BYPASS) |=> !t_r.byp)
    else $error("bypass did not capture zero");

  a_chain_shift: assert property (
    @(posedge TCK) disable iff (!RST_B)
    (TAP_SHIFT_DR && !TAP_RESET && !TAP_CAPTURE_DR && dec.sel == SEL_BOUNDARY
     && !TAP_IDLE) |=> (t_r.bsr_shift == {$past(TDI), $past(t_r.bsr_shift[17:1])}))
    else $error("boundary chain shift order wrong");

  a_chain_reset_hold: assert property (
    @(posedge TCK) disable iff (!RST_B)
    TAP_RESET |=> ($stable(t_r.bsr_shift) && $stable(t_r.bsr_shadow)))
    else $error("boundary chain changed in reset state");

  a_self_invert: assert property (
    @(posedge TCK) disable iff (!RST_B)
    (TAP_CAPTURE_DR && !TAP_RESET && !TAP_IDLE && dec.cap == CAP_INVERT)
    |=> (t_r.bsr_shift == ~$past(t_r.bsr_shadow)))
    else $error("self test did not invert cells");

  a_control_hold: assert property (
    @(posedge TCK) disable iff (!RST_B)
    (TAP_CAPTURE_DR && !TAP_RESET && dec.sel == SEL_CONTROL)
    |=> $stable(t_r.bcr_shift))
    else $error("control register changed at capture");

  a_control_reset: assert property (
    @(posedge TCK) disable iff (!RST_B) TAP_RESET |=> (t_r.boundary_control == 2'b10))
    else $error("control register not reset to 10");

  sequence s_hz_mode;
    s_r.xfer.mode == MODE_HIGHZ;
  endsequence

  sequence s_outs_off;
    !A_OE && !B_OE;
  endsequence

  a_highz_outputs: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B) s_hz_mode |=> s_outs_off)
    else $error("outputs driven in tristate mode");

  a_dir_zero_a_out: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (sys_test && !s_r.xfer.cells[17] && !s_r.xfer.cells[16])
    |=> (A_OE && !B_OE))
    else $error("direction 0 did not drive port A");

endmodule

//--- sim/otsr_tap_master.sv
// Test-bus master model that walks the scan states and moves serial data
`timescale 1ns/1ps
module otsr_tap_master (
  output logic TCK,
  output logic TDI,
  output logic [7:0] ST,
  input wire logic TDO,
  input wire logic TDO_OE
);
  // ***********************************
  // State word: reset idle cir sir uir cdr sdr udr
  // ***********************************
  initial begin
    TCK = 1'b0;
    TDI = 1'b0;
    ST = 8'h00;
  end
  // One TCK period; TCK stands still low between frames
  task automatic step(input logic [7:0] s, input logic d);
    // Change just after the falling edge, never in its time step
    #1 ST = s;
    TDI = d;
    #31 TCK = 1'b1;
    #32 TCK = 1'b0;
  endtask
  // Synchronous return to the reset state, then a neutral state
  task automatic tap_reset();
    step(8'h80, ~TDI);
    step(8'h00, ~TDI);
  endtask
  // Capture, n shifts lsb first, update; TDO read after each falling edge
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout, output logic oe_ok);
    dout = '0;
    oe_ok = 1'b1;
    step(ir ? 8'h20 : 8'h04, ~TDI);
    for (int i = 0; i < n; i++) begin
      step(ir ? 8'h10 : 8'h02, din[i]);
      #1 dout[i] = TDO;
      oe_ok = oe_ok & TDO_OE;
    end
    // TDI is not meaningful outside shift, so it is left toggling
    step(ir ? 8'h08 : 8'h01, ~TDI);
    #1 oe_ok = oe_ok & ~TDO_OE;
    // Neutral state keeps idle operations from running
    step(8'h00, ~TDI);
  endtask
endmodule

//--- sim/octal_transceiver_scan_registers_bench.sv
// Self-checking bench for the octal transceiver scan registers
`timescale 1ns/1ps
module octal_transceiver_scan_registers_bench;
  import otsr_pkg::*;
  // ***********************************
  // Signals and instances
  // ***********************************
  logic clk_sys, rst_b, tck, tdi, tdo, tdo_oe, dir_pin, oe_b_pin;
  logic [7:0] st;
  logic [7:0] a_in, b_in, a_out, b_out;
  logic a_oe, b_oe;
  int mismatches = 0;
  int compares = 0;
  otsr_tap_master tap (.TCK(tck), .TDI(tdi), .ST(st), .TDO(tdo), .TDO_OE(tdo_oe));
  otsr_scan_regs dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .TCK(tck), .TDI(tdi),
    .TDO(tdo), .TDO_OE(tdo_oe), .TAP_RESET(st[7]), .TAP_IDLE(st[6]),
    .TAP_CAPTURE_IR(st[5]), .TAP_SHIFT_IR(st[4]), .TAP_UPDATE_IR(st[3]),
    .TAP_CAPTURE_DR(st[2]), .TAP_SHIFT_DR(st[1]), .TAP_UPDATE_DR(st[0]),
    .DIR_PIN(dir_pin), .OE_B_PIN(oe_b_pin), .A_IN(a_in), .A_OUT(a_out),
    .A_OE(a_oe), .B_IN(b_in), .B_OUT(b_out), .B_OE(b_oe));
  // System clock, 5 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ***********************************
  // Shared tasks
  // ***********************************
  // Verdict and end of run
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Single compare for every kind of result
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Pins change at the falling edge, then the sync path settles
  task automatic pins(input logic d, input logic oeb, input logic [7:0] a, input logic [7:0] b);
    @(negedge clk_sys);
    dir_pin = d;
    oe_b_pin = oeb;
    a_in = a;
    b_in = b;
    repeat (12) @(posedge clk_sys);
  endtask
  // Output enables and the shared output word
  task automatic outs(input logic aoe, input logic boe, input logic [7:0] dat);
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("oe_pair", {aoe, boe}, {a_oe, b_oe});
    chk("out_word", dat, (aoe ? a_out : b_out));
  endtask
  // Instruction scan; the captured pattern and TDO enable are judged each time
  task automatic ir(input logic [7:0] op);
    logic [31:0] d;
    logic ok;
    tap.scan(1'b1, 8, {24'h0, op}, d, ok);
    chk("ir_capture", 32'h81, d);
    chk("tdo_enable", 32'h1, {31'h0, ok});
  endtask
  // Data scan of n bits against an expected read-out
  task automatic dr(input string nm, input int n, input logic [31:0] din, input logic [31:0] e);
    logic [31:0] d;
    logic ok;
    tap.scan(1'b0, n, din, d, ok);
    chk(nm, e, d);
  endtask
  // ***********************************
  // Scenarios
  // ***********************************
  // Normal mode after reset: direction pin steers the data path
  task automatic t_normal();
    pins(1'b0, 1'b0, 8'h3C, 8'hA5);
    outs(1'b1, 1'b0, 8'hA5);
    pins(1'b1, 1'b0, 8'h96, 8'h00);
    outs(1'b0, 1'b1, 8'h96);
  endtask
  // Every bypass-path opcode, bit 7 both ways and undefined codes
  task automatic t_bypass();
    logic [7:0] ops [10] = '{8'h01, 8'h84, 8'h05, 8'h88, 8'h86, 8'h87, 8'h89, 8'h8D, 8'h10,
      8'hFF};
    for (int i = 0; i < 10; i++) begin
      ir(ops[i]);
      dr("bypass_path", 4, 32'hB, 32'h6);
      if (ops[i] == 8'h86) begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("highz_oe", 32'h0, {30'h0, a_oe, b_oe});
      end
    end
  endtask
  // Sample in normal mode, then drive outputs from the cells in test mode
  task automatic t_boundary();
    pins(1'b0, 1'b0, 8'h3C, 8'hA5);
    ir(8'h02);
    dr("sample_capture", 18, 32'h2C35A, 32'h0A5A5);
    outs(1'b1, 1'b0, 8'hA5);
    ir(8'h03);
    outs(1'b0, 1'b1, 8'h5A);
    ir(8'h80);
    dr("extest_capture", 18, 32'h2C35A, 32'h03CC3);
  endtask
  // Self test inverts the shadow; read holds the shift stage
  task automatic t_self();
    ir(8'h0C);
    dr("self_test", 18, 32'h01234, 32'h13CA5);
    ir(8'h0A);
    dr("read_normal", 18, 32'h2AAAA, 32'h01234);
  endtask
  // Control register value, hold on capture, reset, chain untouched
  task automatic t_control();
    ir(8'h0E);
    dr("ctrl_reset", 2, 32'h1, 32'h2);
    dr("ctrl_hold", 2, 32'h3, 32'h1);
    ir(8'h0F);
    dr("ctrl_test", 2, 32'h0, 32'h3);
    tap.tap_reset();
    ir(8'h0E);
    dr("ctrl_after_reset", 2, 32'h2, 32'h2);
    ir(8'h0B);
    dr("chain_kept", 18, 32'h0, 32'h2AAAA);
  endtask
  // ***********************************
  // Main sequence and watchdog
  // ***********************************
  initial begin
    rst_b = 1'b0;
    dir_pin = 1'b0;
    oe_b_pin = 1'b0;
    a_in = 8'h00;
    b_in = 8'h00;
    fork
      tap.step(8'h00, 1'b0);
      begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
      end
    join
    t_normal();
    t_boundary();
    t_self();
    t_control();
    t_bypass();
    wrap_up();
  end
  // Run needs about 27 us; a hang is cut short well after that
  initial begin
    #300us;
    mismatches++;
    wrap_up();
  end
endmodule
